// ===== schp_defs.vh
// Constants for the serial controller host bus port
`ifndef SCHP_DEFS_VH
`define SCHP_DEFS_VH

// Register indices
`define SCHP_REG_CMD        4'h0
`define SCHP_REG_MODE       4'h1
`define SCHP_REG_VECTOR     4'h2
`define SCHP_REG_PENDING    4'h3
`define SCHP_REG_DATA       4'h8
`define SCHP_REG_MASTER     4'h9
`define SCHP_REG_BAUD_LO    4'hc
`define SCHP_REG_BAUD_HI    4'hd

// Command register fields
`define SCHP_CMD_PTR_LSB    0
`define SCHP_CMD_PTR_HI_BIT 3
`define SCHP_CMD_CODE_LSB   3
`define SCHP_CMD_CRC_LSB    6
`define SCHP_CMD_POINT_HIGH 3'h1
`define SCHP_CMD_CRC_NONE   2'h0

// Mode register: pacing function bits
`define SCHP_MODE_PACE_EN   7
`define SCHP_MODE_PACE_REQ  6

// Master control: reset commands in the top two bits
`define SCHP_MASTER_RST_LSB 6
`define SCHP_MASTER_RST_ALL 2'h3
`define SCHP_MASTER_RST_A   2'h2
`define SCHP_MASTER_RST_B   2'h1

// Reset values
`define SCHP_RST_BYTE       8'h00
`define SCHP_RST_MASTER     8'hc0

// Bus timing: the overlap counter holds at this count while the strobes stay together
`define SCHP_COINC_CYCLES   2'h1

`endif

// ===== schp_chan_regs.v
// One channel's private register set with readback
`timescale 1ns/100ps
`include "schp_defs.vh"

module schp_chan_regs (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rstn_i,
    // Access from the bus front end
    input  wire       wr_i,
    input  wire [3:0] idx_i,
    input  wire [7:0] wdata_i,
    input  wire       soft_rst_i,
    // Register views
    input  wire [3:0] rd_idx_i,
    output reg  [7:0] rdata_o,
    output wire       pace_req_o,
    output wire       pace_en_o,
    output wire [1:0] crc_cmd_o
);

    reg [7:0] regs_ff [0:15];
    integer   i;

    // Sixteen writable registers; soft reset puts pacing back to wait
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (i = 0; i < 16; i = i + 1) begin
                regs_ff[i] <= `SCHP_RST_BYTE;
            end
        end else if (soft_rst_i) begin
            regs_ff[`SCHP_REG_MODE] <= `SCHP_RST_BYTE;
        end else if (wr_i) begin
            regs_ff[idx_i] <= wdata_i;
        end
    end

    // Baud bytes read back where they were written, else the stored byte
    always @* begin
        rdata_o = regs_ff[rd_idx_i];
    end

    assign pace_req_o = regs_ff[`SCHP_REG_MODE][`SCHP_MODE_PACE_REQ];
    assign pace_en_o  = regs_ff[`SCHP_REG_MODE][`SCHP_MODE_PACE_EN];
    assign crc_cmd_o  = regs_ff[`SCHP_REG_CMD][`SCHP_CMD_CRC_LSB +: 2];

endmodule // schp_chan_regs

// ===== schp_pace.v
// Wait/request pacing output for one channel
`timescale 1ns/100ps

module schp_pace (
    // Clock and reset
    input  wire clk_i,
    input  wire rstn_i,
    // Function and state
    input  wire enable_i,
    input  wire req_mode_i,
    input  wire ready_i,
    input  wire busy_access_i,
    // Pin, two signals
    output reg  pin_o,
    output reg  pin_oe_n_o
);

    // Wait mode pulls low open-drain while a stalled access waits;
    // request mode drives both levels, low meaning ready
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_o      <= 1'b0;
            pin_oe_n_o <= 1'b1;
        end else if (!enable_i) begin
            pin_o      <= 1'b0;
            pin_oe_n_o <= 1'b1;
        end else if (req_mode_i) begin
            pin_o      <= ~ready_i;
            pin_oe_n_o <= 1'b0;
        end else begin
            pin_o      <= 1'b0;
            pin_oe_n_o <= ~(busy_access_i & ~ready_i);
        end
    end

endmodule // schp_pace

// ===== schp_host_port.v
// Host bus port of a dual channel serial controller
`timescale 1ns/100ps
`include "schp_defs.vh"

module schp_host_port (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rstn_i,
    // Variant select: high chooses the multiplexed bus
    input  wire       muxed_mode_i,
    // Non-multiplexed bus
    input  wire       chan_b_sel_i,
    input  wire       chip_enable_n_i,
    input  wire       data_sel_i,
    input  wire       read_n_i,
    input  wire       write_n_i,
    // Multiplexed bus
    input  wire       address_strobe_n_i,
    input  wire       latched_select_n_i,
    input  wire       level_select_i,
    input  wire       data_strobe_n_i,
    input  wire       read_dir_i,
    // Shared eight bit bus, three signals
    input  wire [7:0] bus_i,
    output reg  [7:0] bus_o,
    output reg        bus_oe_n_o,
    // Interrupt acknowledge and chain
    input  wire       irq_acknowledge_n_i,
    input  wire       prio_chain_in_i,
    input  wire [5:0] pending_i,
    input  wire [2:0] vector_status_i,
    // Channel data paths
    input  wire [7:0] rx_data_a_i,
    input  wire [7:0] rx_data_b_i,
    input  wire [1:0] chan_ready_i,
    output reg  [1:0] tx_load_o,
    output reg  [7:0] tx_data_o,
    output reg  [1:0] rx_take_o,
    // Controls to the channel engines
    output reg  [1:0] crc_cmd_a_o,
    output reg  [1:0] crc_cmd_b_o,
    output reg  [7:0] vector_o,
    output reg  [7:0] master_ctrl_o,
    output reg        coinc_reset_o,
    // Pacing pins, two signals each
    output wire [1:0] pace_o,
    output wire [1:0] pace_oe_n_o
);

    // Access states
    localparam ST_IDLE = 2'd0;
    localparam ST_RD   = 2'd1;
    localparam ST_WR   = 2'd2;
    localparam ST_DONE = 2'd3;

    reg  [1:0] state_ff;
    reg  [1:0] nxt_state;
    reg  [3:0] ptr_ff;
    reg  [3:0] nxt_ptr;
    reg  [7:0] addr_ff;
    reg        cs0_ff;
    reg        ack_ff;
    reg  [1:0] coinc_cnt_ff;
    reg        acc_chan_b_ff;
    reg        acc_data_ff;
    reg  [3:0] acc_idx_ff;
    reg  [7:0] wdata_ff;
    reg        as_d_ff;

    // Front end decode
    reg        sel;
    reg        rd_req;
    reg        wr_req;
    reg        chan_b;
    reg        is_data;
    reg  [3:0] idx;
    reg        coinc;

    wire [7:0] rdata_a;
    wire [7:0] rdata_b;
    wire [1:0] pace_req;
    wire [1:0] pace_en;
    wire [1:0] crc_a;
    wire [1:0] crc_b;
    reg  [7:0] vector_ff;
    reg  [7:0] master_ff;
    reg  [1:0] chan_wr;
    reg  [7:0] rsel;

    // Vector with status in bits 3:1, used by both read paths
    function [7:0] schp_vec_status;
        input [7:0] vec;
        input [2:0] st;
        begin
            schp_vec_status = {vec[7:4], st, vec[0]};
        end
    endfunction

    // Strobe coincidence on either variant
    always @* begin
        if (muxed_mode_i) begin
            coinc = !address_strobe_n_i && !data_strobe_n_i;
        end else begin
            coinc = !read_n_i && !write_n_i;
        end
    end

    // Address phase of the multiplexed bus; caught on the strobe's rising edge
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            as_d_ff <= 1'b1;
            addr_ff <= `SCHP_RST_BYTE;
            cs0_ff  <= 1'b1;
        end else begin
            as_d_ff <= address_strobe_n_i;
            if (!as_d_ff && address_strobe_n_i) begin
                addr_ff <= bus_i;
                cs0_ff  <= latched_select_n_i;
            end
        end
    end

    // Acknowledge input registered on the clock; no pulse shorter is seen
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= !irq_acknowledge_n_i;
        end
    end

    // Decode of the current bus cycle
    always @* begin
        if (muxed_mode_i) begin
            sel     = !cs0_ff && level_select_i && !data_strobe_n_i;
            rd_req  = sel && read_dir_i;
            wr_req  = sel && !read_dir_i;
            chan_b  = addr_ff[4];
            is_data = addr_ff[3:0] == `SCHP_REG_DATA;
            idx     = addr_ff[3:0];
        end else begin
            sel     = !chip_enable_n_i;
            rd_req  = sel && !read_n_i;
            wr_req  = sel && !write_n_i;
            chan_b  = chan_b_sel_i;
            is_data = data_sel_i;
            idx     = is_data ? `SCHP_REG_DATA : ptr_ff;
        end
    end

    // Access sequencer: one register access per strobe assertion
    always @* begin
        nxt_state = state_ff;
        nxt_ptr   = ptr_ff;
        case (state_ff)
            ST_IDLE: begin
                if (coinc) begin
                    nxt_state = ST_DONE;
                end else if (rd_req && !ack_ff) begin
                    nxt_state = ST_RD;
                end else if (wr_req) begin
                    nxt_state = ST_WR;
                end
            end
            ST_RD, ST_WR: begin
                nxt_state = ST_DONE;
                if (!muxed_mode_i && !acc_data_ff) begin
                    if (state_ff == ST_WR && acc_idx_ff == `SCHP_REG_CMD) begin
                        // Point-high code reaches the upper eight registers
                        nxt_ptr = {(wdata_ff[`SCHP_CMD_CODE_LSB +: 3] == `SCHP_CMD_POINT_HIGH),
                                   wdata_ff[`SCHP_CMD_PTR_LSB +: 3]};
                    end else begin
                        nxt_ptr = 4'h0;
                    end
                end
            end
            ST_DONE: begin
                if (!rd_req && !wr_req && !coinc) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (coinc) begin
            nxt_ptr = 4'h0;
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff      <= ST_IDLE;
            ptr_ff        <= 4'h0;
            acc_chan_b_ff <= 1'b0;
            acc_data_ff   <= 1'b0;
            acc_idx_ff    <= 4'h0;
            wdata_ff      <= `SCHP_RST_BYTE;
            coinc_cnt_ff  <= 2'h0;
            coinc_reset_o <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ptr_ff   <= nxt_ptr;
            if (state_ff == ST_IDLE) begin
                acc_chan_b_ff <= chan_b;
                acc_data_ff   <= is_data;
                acc_idx_ff    <= idx;
                wdata_ff      <= bus_i;
            end
            // Pulse once per coincidence so a held overlap resets only once
            if (!coinc) begin
                coinc_cnt_ff <= 2'h0;
            end else if (coinc_cnt_ff != `SCHP_COINC_CYCLES) begin
                coinc_cnt_ff <= coinc_cnt_ff + 2'h1;
            end
            coinc_reset_o <= coinc && coinc_cnt_ff == 2'h0;
        end
    end

    // Write strobes to each channel; shared registers are kept apart
    always @* begin
        chan_wr = 2'b00;
        if (state_ff == ST_WR && acc_idx_ff != `SCHP_REG_VECTOR
                && acc_idx_ff != `SCHP_REG_MASTER) begin
            chan_wr[acc_chan_b_ff] = 1'b1;
        end
    end

    // Shared vector and master control registers, one copy for both channels
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            vector_ff <= `SCHP_RST_BYTE;
            master_ff <= `SCHP_RST_MASTER;
        end else if (state_ff == ST_WR) begin
            if (acc_idx_ff == `SCHP_REG_VECTOR) begin
                vector_ff <= wdata_ff;
            end
            if (acc_idx_ff == `SCHP_REG_MASTER) begin
                master_ff <= wdata_ff;
            end
        end
    end

    // Channel-specific register views
    always @* begin
        case (acc_idx_ff)
            `SCHP_REG_VECTOR: begin
                rsel = acc_chan_b_ff ? schp_vec_status(vector_ff, vector_status_i)
                                     : vector_ff;
            end
            `SCHP_REG_PENDING: begin
                rsel = acc_chan_b_ff ? 8'h00 : {2'b00, pending_i};
            end
            `SCHP_REG_DATA: begin
                rsel = acc_chan_b_ff ? rx_data_b_i : rx_data_a_i;
            end
            `SCHP_REG_BAUD_LO, `SCHP_REG_BAUD_HI: begin
                rsel = acc_chan_b_ff ? rdata_b : rdata_a;
            end
            default: begin
                rsel = acc_chan_b_ff ? rdata_b : rdata_a;
            end
        endcase
    end

    // Data bus drivers; acknowledge reads take precedence over registers
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_o      <= `SCHP_RST_BYTE;
            bus_oe_n_o <= 1'b1;
        end else if (ack_ff && !muxed_mode_i && !read_n_i) begin
            bus_o      <= schp_vec_status(vector_ff, vector_status_i);
            bus_oe_n_o <= ~(prio_chain_in_i && pending_i != 6'h00);
        end else if (state_ff == ST_RD || (state_ff == ST_DONE && rd_req && !coinc)) begin
            if (state_ff == ST_RD) begin
                bus_o <= rsel;
            end
            bus_oe_n_o <= 1'b0;
        end else begin
            bus_oe_n_o <= 1'b1;
        end
    end

    // Data register side effects and control outputs
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_load_o     <= 2'b00;
            tx_data_o     <= `SCHP_RST_BYTE;
            rx_take_o     <= 2'b00;
            crc_cmd_a_o   <= `SCHP_CMD_CRC_NONE;
            crc_cmd_b_o   <= `SCHP_CMD_CRC_NONE;
            vector_o      <= `SCHP_RST_BYTE;
            master_ctrl_o <= `SCHP_RST_MASTER;
        end else begin
            tx_load_o <= {2{state_ff == ST_WR && acc_data_ff}} &
                         {acc_chan_b_ff, !acc_chan_b_ff};
            rx_take_o <= {2{state_ff == ST_RD && acc_idx_ff == `SCHP_REG_DATA}} &
                         {acc_chan_b_ff, !acc_chan_b_ff};
            if (state_ff == ST_WR) begin
                tx_data_o <= wdata_ff;
            end
            crc_cmd_a_o   <= crc_a;
            crc_cmd_b_o   <= crc_b;
            vector_o      <= vector_ff;
            master_ctrl_o <= master_ff;
        end
    end

    // Channel register sets
    schp_chan_regs u_regs_a (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .wr_i       (chan_wr[0]),
        .idx_i      (acc_idx_ff),
        .wdata_i    (wdata_ff),
        .soft_rst_i (coinc_reset_o),
        .rd_idx_i   (acc_idx_ff),
        .rdata_o    (rdata_a),
        .pace_req_o (pace_req[0]),
        .pace_en_o  (pace_en[0]),
        .crc_cmd_o  (crc_a)
    );

    schp_chan_regs u_regs_b (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .wr_i       (chan_wr[1]),
        .idx_i      (acc_idx_ff),
        .wdata_i    (wdata_ff),
        .soft_rst_i (coinc_reset_o),
        .rd_idx_i   (acc_idx_ff),
        .rdata_o    (rdata_b),
        .pace_req_o (pace_req[1]),
        .pace_en_o  (pace_en[1]),
        .crc_cmd_o  (crc_b)
    );

    // Pacing pins; a wait stalls the host while the channel is not ready
    schp_pace u_pace_a (
        .clk_i         (clk_i),
        .rstn_i        (rstn_i),
        .enable_i      (pace_en[0]),
        .req_mode_i    (pace_req[0]),
        .ready_i       (chan_ready_i[0]),
        .busy_access_i (sel && !chan_b && is_data),
        .pin_o         (pace_o[0]),
        .pin_oe_n_o    (pace_oe_n_o[0])
    );

    schp_pace u_pace_b (
        .clk_i         (clk_i),
        .rstn_i        (rstn_i),
        .enable_i      (pace_en[1]),
        .req_mode_i    (pace_req[1]),
        .ready_i       (chan_ready_i[1]),
        .busy_access_i (sel && chan_b && is_data),
        .pin_o         (pace_o[1]),
        .pin_oe_n_o    (pace_oe_n_o[1])
    );

endmodule // schp_host_port

// ===== schp_host_port_assertions.sv
// Concurrent checks on the host bus port pins
`timescale 1ns/100ps
module schp_host_port_assertions (
    // Clock and reset
    input logic       clk_i,
    input logic       rstn_i,
    // Bus inputs
    input logic       muxed_mode_i,
    input logic       chan_b_sel_i,
    input logic       chip_enable_n_i,
    input logic       data_sel_i,
    input logic       read_n_i,
    input logic       write_n_i,
    input logic       address_strobe_n_i,
    input logic       latched_select_n_i,
    input logic       level_select_i,
    input logic       data_strobe_n_i,
    input logic       read_dir_i,
    input logic       irq_acknowledge_n_i,
    input logic       prio_chain_in_i,
    // Outputs watched
    input logic       bus_oe_n_o,
    input logic [1:0] tx_load_o,
    input logic       coinc_reset_o,
    input logic [1:0] pace_oe_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // Selected read strobe that starts and is held through decode
    sequence nm_rd;
        !muxed_mode_i && irq_acknowledge_n_i && !chip_enable_n_i && write_n_i
        && $fell(read_n_i) ##1 !read_n_i;
    endsequence
    // Selected data write on one channel, held through decode
    sequence nm_wr(ch);
        !muxed_mode_i && !chip_enable_n_i && data_sel_i && read_n_i && $fell(write_n_i)
        && chan_b_sel_i == ch ##1 !write_n_i;
    endsequence
    // Multiplexed read after a latched, selected address
    sequence mx_rd;
        muxed_mode_i && level_select_i && !latched_select_n_i && read_dir_i
        && address_strobe_n_i && $fell(data_strobe_n_i) ##1 !data_strobe_n_i;
    endsequence

    read_resp_a: assert property (nm_rd |-> ##1 !bus_oe_n_o)
        else $error("read drivers not on in time");
    ce_gate_a: assert property ((!muxed_mode_i && irq_acknowledge_n_i
        && chip_enable_n_i)[*4] |-> bus_oe_n_o)
        else $error("drivers on while not selected");
    load_a_a: assert property (nm_wr(1'b0) |-> ##1 tx_load_o == 2'h1)
        else $error("channel A data write not loaded");
    load_b_a: assert property (nm_wr(1'b1) |-> ##1 tx_load_o == 2'h2)
        else $error("channel B data write not steered");
    coinc_nm_a: assert property (!muxed_mode_i && !read_n_i && !write_n_i
        && $past(read_n_i || write_n_i) |=> coinc_reset_o)
        else $error("read and write together gave no reset");
    coinc_mx_a: assert property (muxed_mode_i && !address_strobe_n_i && !data_strobe_n_i
        && $past(address_strobe_n_i || data_strobe_n_i) |=> coinc_reset_o)
        else $error("address and data strobe together gave no reset");
    pace_wait_a: assert property (coinc_reset_o |-> ##[0:2] pace_oe_n_o == 2'h3)
        else $error("pacing not back to wait after reset");
    vec_gate_a: assert property ((!muxed_mode_i && !irq_acknowledge_n_i
        && !prio_chain_in_i)[*4] |-> bus_oe_n_o)
        else $error("vector driven with chain input low");
    mux_read_a: assert property (mx_rd |-> ##1 !bus_oe_n_o)
        else $error("multiplexed read drivers not on in time");
    sel_gate_a: assert property ((muxed_mode_i && !level_select_i)[*4] |-> bus_oe_n_o)
        else $error("drivers on without second select");
endmodule // schp_host_port_assertions

// ===== schp_host_model.sv
// Host processor model driving both bus variants of the port
`timescale 1ns/100ps
module schp_host_model (
    // Clock
    input  wire       clk_i,
    // Device drive on the shared bus
    input  wire [7:0] dev_bus_i,
    input  wire       dev_oe_n_i,
    // Non-multiplexed bus
    output reg        chan_b_sel_o,
    output reg        chip_enable_n_o,
    output reg        data_sel_o,
    output reg        read_n_o,
    output reg        write_n_o,
    // Multiplexed bus
    output reg        address_strobe_n_o,
    output reg        latched_select_n_o,
    output reg        level_select_o,
    output reg        data_strobe_n_o,
    output reg        read_dir_o,
    // Resolved shared bus
    output wire [7:0] bus_o
);
    reg [7:0] drv_ff;
    // Device owns the wire while driving; a released host value is inverted, never stale
    assign bus_o = dev_oe_n_i ? drv_ff : dev_bus_i;
    // Idle levels
    initial begin
        {chan_b_sel_o, data_sel_o, level_select_o, read_dir_o} = 4'h0;
        {chip_enable_n_o, read_n_o, write_n_o} = 3'h7;
        {address_strobe_n_o, latched_select_n_o, data_strobe_n_o} = 3'h7;
        drv_ff = 8'h00;
    end
    // Non-multiplexed access: strobe held for the whole walk, then idle
    task nm_access(input logic ch, input logic sel, input logic dsel, input logic rd,
                   input logic [7:0] wd, output logic [7:0] rdat);
        begin
            @(negedge clk_i);
            chan_b_sel_o = ch;
            chip_enable_n_o = !sel;
            data_sel_o = dsel;
            drv_ff = rd ? ~wd : wd;
            read_n_o = !rd;
            write_n_o = rd;
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            rdat = bus_o;
            {chip_enable_n_o, read_n_o, write_n_o} = 3'h7;
            drv_ff = ~drv_ff;
            repeat (2) @(negedge clk_i);
        end
    endtask
    // Multiplexed access: address phase, then data phase under both selects
    task mx_access(input logic ch, input logic [3:0] idx, input logic rd,
                   input logic [7:0] wd, output logic [7:0] rdat);
        begin
            @(negedge clk_i);
            level_select_o = 1'b1;
            latched_select_n_o = 1'b0;
            read_dir_o = rd;
            drv_ff = {3'h0, ch, idx};
            address_strobe_n_o = 1'b0;
            repeat (2) @(negedge clk_i);
            address_strobe_n_o = 1'b1;
            repeat (2) @(negedge clk_i);
            drv_ff = rd ? ~drv_ff : wd;
            data_strobe_n_o = 1'b0;
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            rdat = bus_o;
            data_strobe_n_o = 1'b1;
            @(negedge clk_i);
            level_select_o = 1'b0;
            latched_select_n_o = 1'b1;
            drv_ff = ~drv_ff;
            @(negedge clk_i);
        end
    endtask
    // Both strobes of one variant together
    task coincide(input logic mx);
        begin
            @(negedge clk_i);
            if (mx) begin
                {address_strobe_n_o, data_strobe_n_o} = 2'h0;
            end else begin
                {chip_enable_n_o, read_n_o, write_n_o} = 3'h0;
            end
            repeat (2) @(negedge clk_i);
            {chip_enable_n_o, read_n_o, write_n_o} = 3'h7;
            {address_strobe_n_o, data_strobe_n_o} = 2'h3;
            repeat (2) @(negedge clk_i);
        end
    endtask
endmodule // schp_host_model

// ===== schp_host_port_tb.sv
// Self-checking bench for the host bus port
`timescale 1ns/100ps
module schp_host_port_tb;
    reg         clk_i;
    reg         rstn_i;
    reg         muxed_mode;
    reg         irq_ack_n;
    reg         prio_in;
    reg  [5:0]  pending;
    reg  [2:0]  vstat;
    reg  [1:0]  ready;
    wire        b_sel, ce_n, dsel, rd_n, wr_n, as_n, cs0_n, cs1, ds_n, rdir;
    wire [7:0]  bus_in, bus_out, tx_data, vector, master;
    wire        bus_oe_n;
    wire [1:0]  pace_oe_n, crc_a;
    logic [7:0] got;
    logic [25:0] rows [0:6];
    integer     fail_count, n_checks, i;

    schp_host_model u_host (.clk_i(clk_i), .dev_bus_i(bus_out), .dev_oe_n_i(bus_oe_n),
        .chan_b_sel_o(b_sel), .chip_enable_n_o(ce_n), .data_sel_o(dsel), .read_n_o(rd_n),
        .write_n_o(wr_n), .address_strobe_n_o(as_n), .latched_select_n_o(cs0_n),
        .level_select_o(cs1), .data_strobe_n_o(ds_n), .read_dir_o(rdir), .bus_o(bus_in));
    schp_host_port u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .muxed_mode_i(muxed_mode),
        .chan_b_sel_i(b_sel), .chip_enable_n_i(ce_n), .data_sel_i(dsel), .read_n_i(rd_n),
        .write_n_i(wr_n), .address_strobe_n_i(as_n), .latched_select_n_i(cs0_n),
        .level_select_i(cs1), .data_strobe_n_i(ds_n), .read_dir_i(rdir), .bus_i(bus_in),
        .bus_o(bus_out), .bus_oe_n_o(bus_oe_n), .irq_acknowledge_n_i(irq_ack_n),
        .prio_chain_in_i(prio_in), .pending_i(pending), .vector_status_i(vstat),
        .rx_data_a_i(8'h81), .rx_data_b_i(8'h42), .chan_ready_i(ready), .tx_load_o(),
        .tx_data_o(tx_data), .rx_take_o(), .crc_cmd_a_o(crc_a), .crc_cmd_b_o(),
        .vector_o(vector), .master_ctrl_o(master), .coinc_reset_o(), .pace_o(),
        .pace_oe_n_o(pace_oe_n));

    // Clock at 50 MHz
    always #10 clk_i = ~clk_i;

    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // Control access: pointer byte first, so the next access reaches that register
    task ctl(input logic ch, input logic [3:0] idx, input logic rd, input logic [7:0] wd);
        begin
            u_host.nm_access(ch, 1'b1, 1'b0, 1'b0, {4'h0, idx}, got);
            u_host.nm_access(ch, 1'b1, 1'b0, rd, wd, got);
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", n_checks, fail_count);
            if (fail_count == 0 && n_checks > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count = fail_count + 1;
        close_out;
    end

    // Main sequence: rows of write channel, index, data, read channel, index, expected
    initial begin
        {clk_i, rstn_i, muxed_mode, prio_in, fail_count, n_checks} = 0;
        {irq_ack_n, pending, vstat, ready} = {1'b1, 6'h2d, 3'h5, 2'h3};
        rows = '{{1'b0, 4'hc, 8'h5a, 1'b0, 4'hc, 8'h5a}, {1'b1, 4'hd, 8'ha5, 1'b1, 4'hd, 8'ha5},
                 {1'b1, 4'h2, 8'h30, 1'b0, 4'h2, 8'h30}, {1'b0, 4'h2, 8'hf0, 1'b1, 4'h2, 8'hfa},
                 {1'b0, 4'h3, 8'h00, 1'b0, 4'h3, 8'h2d}, {1'b0, 4'h3, 8'h00, 1'b1, 4'h3, 8'h00},
                 {1'b0, 4'hc, 8'h11, 1'b1, 4'hc, 8'h00}};
        repeat (16) @(posedge clk_i);
        @(negedge clk_i);
        rstn_i = 1'b1;
        chk("oe after reset", {7'h0, bus_oe_n}, 8'h01);
        chk("pacing after reset", {6'h0, pace_oe_n}, 8'h03);
        chk("master after reset", master, 8'hc0);
        $display("test reset done");
        for (i = 0; i < 7; i = i + 1) begin
            ctl(rows[i][25], rows[i][24:21], 1'b0, rows[i][20:13]);
            ctl(rows[i][12], rows[i][11:8], 1'b1, 8'h00);
            chk("row readback", got, rows[i][7:0]);
        end
        $display("test rows done");
        // Data accesses bypass the pointer
        u_host.nm_access(1'b0, 1'b1, 1'b1, 1'b0, 8'h3c, got);
        chk("tx data A", tx_data, 8'h3c);
        u_host.nm_access(1'b1, 1'b1, 1'b1, 1'b0, 8'hc3, got);
        chk("tx data B", tx_data, 8'hc3);
        u_host.nm_access(1'b0, 1'b1, 1'b1, 1'b1, 8'h00, got);
        chk("rx data A", got, 8'h81);
        ctl(1'b1, 4'h9, 1'b0, 8'h05);
        chk("master via B", master, 8'h05);
        chk("vector shared", vector, 8'hf0);
        u_host.nm_access(1'b0, 1'b1, 1'b0, 1'b0, 8'h80, got);
        chk("crc command A", {6'h0, crc_a}, 8'h02);
        $display("test data done");
        // Acknowledge reads; zero status keeps both vector views equal
        {irq_ack_n, prio_in, vstat} = {1'b0, 1'b1, 3'h0};
        u_host.nm_access(1'b0, 1'b1, 1'b0, 1'b1, 8'h00, got);
        chk("ack vector", got, 8'hf0);
        prio_in = 1'b0;
        u_host.nm_access(1'b0, 1'b1, 1'b0, 1'b1, 8'h00, got);
        chk("ack blocked", got, 8'hff);
        irq_ack_n = 1'b1;
        $display("test acknowledge done");
        // Request function on A, then a strobe coincidence returns it to wait
        ctl(1'b0, 4'h1, 1'b0, 8'hc0);
        chk("pacing request", {6'h0, pace_oe_n}, 8'h02);
        u_host.coincide(1'b0);
        chk("pacing after coincidence", {6'h0, pace_oe_n}, 8'h03);
        $display("test coincidence done");
        // Multiplexed variant: address bit four picks channel B
        muxed_mode = 1'b1;
        u_host.mx_access(1'b1, 4'hc, 1'b0, 8'h6b, got);
        u_host.mx_access(1'b1, 4'hc, 1'b1, 8'h00, got);
        chk("mux readback B", got, 8'h6b);
        u_host.mx_access(1'b0, 4'hc, 1'b1, 8'h00, got);
        chk("mux readback A", got, 8'h11);
        u_host.mx_access(1'b1, 4'h1, 1'b0, 8'hc0, got);
        chk("mux pacing request", {6'h0, pace_oe_n}, 8'h01);
        u_host.coincide(1'b1);
        chk("mux coincidence", {6'h0, pace_oe_n}, 8'h03);
        $display("test multiplexed done");
        close_out;
    end
endmodule // schp_host_port_tb

bind schp_host_port schp_host_port_assertions u_chk (.clk_i, .rstn_i, .muxed_mode_i,
    .chan_b_sel_i, .chip_enable_n_i, .data_sel_i, .read_n_i, .write_n_i, .address_strobe_n_i,
    .latched_select_n_i, .level_select_i, .data_strobe_n_i, .read_dir_i, .irq_acknowledge_n_i,
    .prio_chain_in_i, .bus_oe_n_o, .tx_load_o, .coinc_reset_o, .pace_oe_n_o);
